// *** rtl/ccf_pkg.sv ***
package ccf_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          LANES           = 4;

  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_CFG        = 8'h04;

  localparam logic [31:0] CFG_RESET       = 32'h2000_0000;
  localparam logic [31:0] CFG_RW_MASK     = 32'hffff_0000;
  localparam logic [31:0] CFG_LOCK_MASK   = 32'h083f_0000;
  localparam logic        PLL_EN_RESET    = 1'h0;

  localparam int          DIV_LSB         = 28;
  localparam int          MUL_HI_BIT      = 27;
  localparam int          SEL_LSB         = 24;
  localparam int          USB_LSB         = 22;
  localparam int          MUL_LO_LSB      = 18;
  localparam int          PREDIV_BIT      = 17;
  localparam int          SRC_BIT         = 16;
  localparam int          PLL_EN_BIT      = 24;

  localparam logic [3:0]  DIV_MIN_LEGAL   = 4'h2;
  localparam logic [3:0]  DIV_RESET       = 4'h2;
  localparam logic [4:0]  MUL_LOW_TOP     = 5'h0e;
  localparam logic [4:0]  MUL_DUP_CODE    = 5'h0f;
  localparam logic [5:0]  MUL_DUP_FACTOR  = 6'h10;
  localparam logic [5:0]  MUL_LOW_ADD     = 6'h02;
  localparam logic [5:0]  MUL_HIGH_ADD    = 6'h01;
  localparam logic [5:0]  MUL_RESET       = 6'h02;

  localparam logic [1:0]  USB_DIV_1P5     = 2'h0;
  localparam logic [1:0]  USB_DIV_1       = 2'h1;
  localparam logic [1:0]  USB_DIV_2       = 2'h2;
  localparam logic [2:0]  USB_HALVES_1P5  = 3'h3;
  localparam logic [2:0]  USB_HALVES_1    = 3'h2;
  localparam logic [2:0]  USB_HALVES_2    = 3'h4;
  localparam logic [2:0]  USB_HALVES_3    = 3'h6;

  typedef enum logic [2:0] {
    SRC_NONE     = 3'b000,
    SRC_SYSTEM   = 3'b100,
    SRC_INTERNAL = 3'b101,
    SRC_EXTERNAL = 3'b110,
    SRC_PLL_DIV  = 3'b111
  } ccf_out_src_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } ccf_bus_state_t;

endpackage : ccf_pkg

// *** rtl/ccf_fields_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ccf_fields_if;
  logic [31:0]          cfg;
  logic [5:0]           mul_factor;
  logic [2:0]           usb_halves;
  logic [3:0]           out_div;
  logic                 out_div_legal;
  ccf_pkg::ccf_out_src_t out_src;

  modport regs (output cfg, input mul_factor, usb_halves, out_div, out_div_legal, out_src);
  modport dec  (input cfg, output mul_factor, usb_halves, out_div, out_div_legal, out_src);
endinterface : ccf_fields_if
`default_nettype wire

// *** rtl/ccf_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccf_decode (
  ccf_fields_if.dec f
);

  function automatic logic div_legal(input logic [3:0] code);
    div_legal = (code >= ccf_pkg::DIV_MIN_LEGAL);
  endfunction : div_legal

  function automatic logic [5:0] mul_of(input logic [4:0] code);
    if (code <= ccf_pkg::MUL_LOW_TOP) begin
      mul_of = {1'b0, code} + ccf_pkg::MUL_LOW_ADD;
    end else if (code == ccf_pkg::MUL_DUP_CODE) begin
      mul_of = ccf_pkg::MUL_DUP_FACTOR;
    end else begin
      mul_of = {1'b0, code} + ccf_pkg::MUL_HIGH_ADD;
    end
  endfunction : mul_of

  logic [3:0] div_code;
  logic [4:0] mul_code;
  logic [1:0] usb_code;
  logic [2:0] sel_code;

  always_comb begin
    div_code        = f.cfg[ccf_pkg::DIV_LSB +: 4];
    mul_code        = {f.cfg[ccf_pkg::MUL_HI_BIT], f.cfg[ccf_pkg::MUL_LO_LSB +: 4]};
    usb_code        = f.cfg[ccf_pkg::USB_LSB +: 2];
    sel_code        = f.cfg[ccf_pkg::SEL_LSB +: 3];
    f.out_div_legal = div_legal(div_code);
    f.out_div       = div_legal(div_code) ? div_code : ccf_pkg::DIV_RESET;
    f.mul_factor    = mul_of(mul_code);
    case (usb_code)
      ccf_pkg::USB_DIV_1P5: f.usb_halves = ccf_pkg::USB_HALVES_1P5;
      ccf_pkg::USB_DIV_1:   f.usb_halves = ccf_pkg::USB_HALVES_1;
      ccf_pkg::USB_DIV_2:   f.usb_halves = ccf_pkg::USB_HALVES_2;
      default:              f.usb_halves = ccf_pkg::USB_HALVES_3;
    endcase
    case (sel_code)
      3'b100:  f.out_src = ccf_pkg::SRC_SYSTEM;
      3'b101:  f.out_src = ccf_pkg::SRC_INTERNAL;
      3'b110:  f.out_src = ccf_pkg::SRC_EXTERNAL;
      3'b111:  f.out_src = ccf_pkg::SRC_PLL_DIV;
      default: f.out_src = ccf_pkg::SRC_NONE;
    endcase
  end

endmodule : ccf_decode
`default_nettype wire

// *** rtl/ccf_clock_config.sv ***
// Behaviour
// - Bits 31:28 give the clock-output divider, codes 2 to 15 divide by their value and lower codes are illegal.
// - The five-bit PLL multiplier code is bit 27 on top of bits 21:18.
// - Bits 26:24 pick the clock-output source, 0xx none, then system, internal, external and divided PLL.
// - Source and divider changes reach the outputs one clock after the register is written, so the output clock may show truncated pulses.
// - Bits 23:22 set the USB divider from the PLL clock as 1.5, 1, 2 or 3.
// - Multiplier codes up to 14 give code plus two, code 15 gives sixteen, higher codes give code plus one.
// - Multiplier, predivider and PLL source fields ignore writes while the PLL is enabled.
// - Bit 17 set halves the external oscillator ahead of the PLL, clear passes it.
// - Bit 16 clear feeds the halved internal oscillator to the PLL, set feeds the external path.
// - The configuration register resets to 0x2000_0000.
// - PLL enable is set and cleared by software, cleared by hardware on low-power entry, and kept against software clears while it drives the system clock.
`timescale 1ns/1ps
`default_nettype none
module ccf_clock_config (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  wb_cyc,
  input  wire logic                  wb_stb,
  input  wire logic                  wb_we,
  input  wire logic [7:0]            wb_adr,
  input  wire logic [3:0]            wb_sel,
  input  wire logic [31:0]           wb_dat_w,
  output var  logic [31:0]           wb_dat_r,
  output var  logic                  wb_ack,
  input  wire logic                  low_power_entry,
  input  wire logic                  pll_drives_system_clock,
  output var  logic                  pll_enable,
  output var  logic [5:0]            pll_multiplier,
  output var  logic                  pll_ext_predivider,
  output var  logic                  pll_input_source,
  output var  logic [2:0]            usb_clock_divider,
  output var  logic [3:0]            clock_output_divider,
  output var  logic                  clock_output_div_illegal,
  output var  ccf_pkg::ccf_out_src_t clock_output_select
);

  ccf_fields_if f ();

  ccf_decode u_decode (
    .f (f.dec)
  );

  ccf_pkg::ccf_bus_state_t st_ff,       nxt_st;
  logic                    ack_ff,      nxt_ack;
  logic [31:0]             rdat_ff,     nxt_rdat;
  logic [31:0]             cfg_ff,      nxt_cfg;
  logic                    pll_en_ff,   nxt_pll_en;
  logic [5:0]              mul_ff,      nxt_mul;
  logic                    prediv_ff,   nxt_prediv;
  logic                    src_ff,      nxt_src;
  logic [2:0]              usb_ff,      nxt_usb;
  logic [3:0]              div_ff,      nxt_div;
  logic                    illegal_ff,  nxt_illegal;
  ccf_pkg::ccf_out_src_t   osel_ff,     nxt_osel;

  logic [31:0] lane_mask;
  logic [31:0] cfg_mask;
  logic        commit;
  logic        cfg_wr;
  logic        ctrl_wr;

  genvar g;
  generate
    for (g = 0; g < ccf_pkg::LANES; g = g + 1) begin : g_lane
      assign lane_mask[8*g +: 8] = {8{wb_sel[g]}};
    end
  endgenerate

  assign f.cfg    = cfg_ff;
  assign commit   = (st_ff == ccf_pkg::BUS_ACK) && wb_cyc && wb_stb && wb_we;
  assign cfg_wr   = commit && (wb_adr == ccf_pkg::ADDR_CFG);
  assign ctrl_wr  = commit && (wb_adr == ccf_pkg::ADDR_CTRL) && wb_sel[3];
  assign cfg_mask = lane_mask & ccf_pkg::CFG_RW_MASK
                    & ~(pll_en_ff ? ccf_pkg::CFG_LOCK_MASK : 32'h0000_0000);

  // Bus answer: one cycle after the request is seen, writes land on the ack edge.
  always_comb begin
    nxt_st   = st_ff;
    nxt_ack  = 1'b0;
    nxt_rdat = rdat_ff;
    case (st_ff)
      ccf_pkg::BUS_IDLE: begin
        if (wb_cyc && wb_stb) begin
          nxt_st  = ccf_pkg::BUS_ACK;
          nxt_ack = 1'b1;
          case (wb_adr)
            ccf_pkg::ADDR_CFG:  nxt_rdat = cfg_ff;
            ccf_pkg::ADDR_CTRL: nxt_rdat = {7'h00, pll_en_ff, 24'h00_0000};
            default:            nxt_rdat = 32'h0000_0000;
          endcase
        end
      end
      ccf_pkg::BUS_ACK: begin
        nxt_st = ccf_pkg::BUS_IDLE;
      end
      default: begin
        nxt_st = ccf_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff   <= ccf_pkg::BUS_IDLE;
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      st_ff   <= nxt_st;
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Register state and the decoded field outputs.
  always_comb begin
    nxt_cfg = cfg_ff;
    if (cfg_wr) begin
      nxt_cfg = (cfg_ff & ~cfg_mask) | (wb_dat_w & cfg_mask);
    end
    nxt_pll_en = pll_en_ff;
    if (ctrl_wr) begin
      nxt_pll_en = wb_dat_w[ccf_pkg::PLL_EN_BIT] || (pll_en_ff && pll_drives_system_clock);
    end
    if (low_power_entry) begin
      nxt_pll_en = 1'b0;
    end
    nxt_mul     = f.mul_factor;
    nxt_prediv  = cfg_ff[ccf_pkg::PREDIV_BIT];
    nxt_src     = cfg_ff[ccf_pkg::SRC_BIT];
    nxt_usb     = f.usb_halves;
    nxt_illegal = !f.out_div_legal;
    nxt_div     = f.out_div_legal ? f.out_div : div_ff;
    nxt_osel    = f.out_src;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_ff     <= ccf_pkg::CFG_RESET;
      pll_en_ff  <= ccf_pkg::PLL_EN_RESET;
      mul_ff     <= ccf_pkg::MUL_RESET;
      prediv_ff  <= 1'b0;
      src_ff     <= 1'b0;
      usb_ff     <= ccf_pkg::USB_HALVES_1P5;
      div_ff     <= ccf_pkg::DIV_RESET;
      illegal_ff <= 1'b0;
      osel_ff    <= ccf_pkg::SRC_NONE;
    end else begin
      cfg_ff     <= nxt_cfg;
      pll_en_ff  <= nxt_pll_en;
      mul_ff     <= nxt_mul;
      prediv_ff  <= nxt_prediv;
      src_ff     <= nxt_src;
      usb_ff     <= nxt_usb;
      div_ff     <= nxt_div;
      illegal_ff <= nxt_illegal;
      osel_ff    <= nxt_osel;
    end
  end

  assign wb_dat_r                 = rdat_ff;
  assign wb_ack                   = ack_ff;
  assign pll_enable               = pll_en_ff;
  assign pll_multiplier           = mul_ff;
  assign pll_ext_predivider       = prediv_ff;
  assign pll_input_source         = src_ff;
  assign usb_clock_divider        = usb_ff;
  assign clock_output_divider     = div_ff;
  assign clock_output_div_illegal = illegal_ff;
  assign clock_output_select      = osel_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_value: assert property ($fell(rst) |-> cfg_ff == 32'h2000_0000)
    else $error("Configuration register left reset with a wrong value.");

  a_lock_holds: assert property (cfg_wr && pll_en_ff |=> $stable(cfg_ff & 32'h083f_0000))
    else $error("Locked PLL field changed while the PLL was enabled.");

  a_lock_open: assert property (cfg_wr && !pll_en_ff && (wb_sel == 4'hf)
                                |=> (cfg_ff & 32'h083f_0000) == ($past(wb_dat_w) & 32'h083f_0000))
    else $error("PLL field write was lost while the PLL was disabled.");

  a_mul_factor: assert property (##1 1'b1 |-> mul_ff ==
      (($past({cfg_ff[27], cfg_ff[21:18]}) <= 5'h0e) ? {1'b0, $past({cfg_ff[27], cfg_ff[21:18]})} + 6'h02 :
       ($past({cfg_ff[27], cfg_ff[21:18]}) == 5'h0f) ? 6'h10 :
       {1'b0, $past({cfg_ff[27], cfg_ff[21:18]})} + 6'h01))
    else $error("PLL multiplier output does not match the multiplier code.");

  a_div_code: assert property (cfg_ff[31:28] >= 4'h2 |=> !illegal_ff && div_ff == $past(cfg_ff[31:28]))
    else $error("Legal clock-output divider code not passed through.");

  a_div_illegal: assert property (cfg_ff[31:28] < 4'h2 |=> illegal_ff && $stable(div_ff))
    else $error("Illegal clock-output divider code not flagged or not held off.");

  a_src_none: assert property (!cfg_ff[26] ##1 !cfg_ff[26] |-> osel_ff == ccf_pkg::SRC_NONE)
    else $error("Clock output selected while the select code asks for none.");

  a_src_pick: assert property (cfg_ff[26] |=> osel_ff == $past(cfg_ff[26:24]))
    else $error("Clock-output source does not follow the select code.");

  a_usb_div: assert property (cfg_ff[23:22] == 2'b00 |=> usb_ff == 3'h3)
    else $error("USB divide-by-1.5 setting not reflected.");

  a_pll_input: assert property (##1 1'b1 |-> src_ff == $past(cfg_ff[16]) && prediv_ff == $past(cfg_ff[17]))
    else $error("PLL source or predivider output does not follow its bit.");

  a_pll_hw_clear: assert property (low_power_entry |=> !pll_en_ff)
    else $error("PLL enable survived a low-power entry.");

  a_pll_keep: assert property (pll_en_ff && pll_drives_system_clock && !low_power_entry |=> pll_en_ff)
    else $error("PLL enable cleared while the PLL drives the system clock.");

  a_read_back: assert property (st_ff == ccf_pkg::BUS_IDLE && wb_cyc && wb_stb && wb_adr == 8'h04
                                |=> wb_ack && wb_dat_r == $past(cfg_ff))
    else $error("Configuration read did not return the held value.");

  a_ack_once: assert property (wb_ack |=> !wb_ack)
    else $error("Bus answer held for more than one cycle.");

  a_ack_follows: assert property (st_ff == ccf_pkg::BUS_IDLE && wb_cyc && wb_stb |=> wb_ack)
    else $error("Bus request was not answered in the next cycle.");

  a_ack_quiet: assert property (st_ff == ccf_pkg::BUS_IDLE && !(wb_cyc && wb_stb) |=> !wb_ack)
    else $error("Bus answer given without a request.");

  a_ctrl_read: assert property (st_ff == ccf_pkg::BUS_IDLE && wb_cyc && wb_stb && wb_adr == 8'h00
                                |=> wb_dat_r == {7'h00, $past(pll_en_ff), 24'h00_0000})
    else $error("Control read did not return the PLL enable state.");

  a_unmapped_read: assert property (st_ff == ccf_pkg::BUS_IDLE && wb_cyc && wb_stb
                                    && wb_adr != 8'h00 && wb_adr != 8'h04 |=> wb_dat_r == 32'h0000_0000)
    else $error("Unmapped read did not return zero.");

  a_cfg_quiet: assert property (!cfg_wr |=> $stable(cfg_ff))
    else $error("Configuration register changed without a write.");

  a_lane3_keep: assert property (cfg_wr && !wb_sel[3] |=> $stable(cfg_ff[31:24]))
    else $error("Disabled byte lane 3 was written.");

  a_lane2_keep: assert property (cfg_wr && !wb_sel[2] |=> $stable(cfg_ff[23:16]))
    else $error("Disabled byte lane 2 was written.");

  a_open_fields: assert property (cfg_wr && wb_sel[3] |=> cfg_ff[31:28] == $past(wb_dat_w[31:28])
                                  && cfg_ff[26:24] == $past(wb_dat_w[26:24]))
    else $error("Unlocked clock-output field write was lost.");

  a_usb_write: assert property (cfg_wr && wb_sel[2] |=> cfg_ff[23:22] == $past(wb_dat_w[23:22]))
    else $error("USB divider write was lost.");

  a_reserved_zero: assert property (cfg_ff[15:0] == 16'h0000)
    else $error("Low configuration bits are not zero.");

  a_usb_direct: assert property (cfg_ff[23:22] == 2'b01 |=> usb_ff == 3'h2)
    else $error("USB undivided setting not reflected.");

  a_usb_half: assert property (cfg_ff[23:22] == 2'b10 |=> usb_ff == 3'h4)
    else $error("USB divide-by-2 setting not reflected.");

  a_usb_third: assert property (cfg_ff[23:22] == 2'b11 |=> usb_ff == 3'h6)
    else $error("USB divide-by-3 setting not reflected.");

  a_mul_dup: assert property ({cfg_ff[27], cfg_ff[21:18]} == 5'h0f |=> mul_ff == 6'h10)
    else $error("Multiplier code 15 does not give sixteen.");

  a_mul_top: assert property ({cfg_ff[27], cfg_ff[21:18]} == 5'h1f |=> mul_ff == 6'h20)
    else $error("Top multiplier code does not give thirty-two.");

  a_mul_range: assert property (mul_ff >= 6'h02 && mul_ff <= 6'h20)
    else $error("PLL multiplier output out of range.");

  a_div_range: assert property (div_ff >= 4'h2)
    else $error("Clock-output divider output is an illegal code.");

  a_src_system: assert property (cfg_ff[26:24] == 3'b100 |=> osel_ff == ccf_pkg::SRC_SYSTEM)
    else $error("System clock selection not reflected.");

  a_src_pll: assert property (cfg_ff[26:24] == 3'b111 |=> osel_ff == ccf_pkg::SRC_PLL_DIV)
    else $error("Divided PLL selection not reflected.");

  a_pll_sw_set: assert property (ctrl_wr && wb_dat_w[24] && !low_power_entry |=> pll_en_ff)
    else $error("Software could not set the PLL enable.");

  a_pll_sw_clear: assert property (ctrl_wr && !wb_dat_w[24] && !pll_drives_system_clock
                                   && !low_power_entry |=> !pll_en_ff)
    else $error("Software could not clear the PLL enable.");

  a_pll_en_hold: assert property (!ctrl_wr && !low_power_entry |=> $stable(pll_en_ff))
    else $error("PLL enable changed without a cause.");

  a_reset_outputs: assert property ($fell(rst) |-> mul_ff == 6'h02 && usb_ff == 3'h3 && div_ff == 4'h2
                                    && osel_ff == ccf_pkg::SRC_NONE && !pll_en_ff && !wb_ack && !illegal_ff)
    else $error("Outputs left reset with wrong values.");

endmodule : ccf_clock_config
`default_nettype wire

// *** testbench/tb_ccf_clock_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ccf_clock_config;
  logic                  clk_sys;
  logic                  rst;
  logic                  wb_cyc;
  logic                  wb_stb;
  logic                  wb_we;
  logic [7:0]            wb_adr;
  logic [3:0]            wb_sel;
  logic [31:0]           wb_dat_w;
  logic [31:0]           wb_dat_r;
  logic                  wb_ack;
  logic                  low_power_entry;
  logic                  pll_drives_system_clock;
  logic                  pll_enable;
  logic [5:0]            pll_multiplier;
  logic                  pll_ext_predivider;
  logic                  pll_input_source;
  logic [2:0]            usb_clock_divider;
  logic [3:0]            clock_output_divider;
  logic                  clock_output_div_illegal;
  ccf_pkg::ccf_out_src_t clock_output_select;
  int                    n_errors;
  int                    check_count;
  integer                seed;
  int                    k;
  logic [31:0]           d;
  logic [31:0]           rd;
  logic [31:0]           cfg_m;
  logic                  en_m;
  logic [3:0]            div_m;

  ccf_clock_config dut (
    .clk_sys                  (clk_sys),
    .rst                      (rst),
    .wb_cyc                   (wb_cyc),
    .wb_stb                   (wb_stb),
    .wb_we                    (wb_we),
    .wb_adr                   (wb_adr),
    .wb_sel                   (wb_sel),
    .wb_dat_w                 (wb_dat_w),
    .wb_dat_r                 (wb_dat_r),
    .wb_ack                   (wb_ack),
    .low_power_entry          (low_power_entry),
    .pll_drives_system_clock  (pll_drives_system_clock),
    .pll_enable               (pll_enable),
    .pll_multiplier           (pll_multiplier),
    .pll_ext_predivider       (pll_ext_predivider),
    .pll_input_source         (pll_input_source),
    .usb_clock_divider        (usb_clock_divider),
    .clock_output_divider     (clock_output_divider),
    .clock_output_div_illegal (clock_output_div_illegal),
    .clock_output_select      (clock_output_select)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_fields();
    int code;
    int mul;
    int u;
    code = {cfg_m[27], cfg_m[21:18]};
    mul  = (code <= 14) ? code + 2 : (code == 15) ? 16 : code + 1;
    u    = cfg_m[23:22];
    chk("pll_multiplier", 32'(mul), 32'(pll_multiplier));
    chk("usb_div", 32'((u == 0) ? 3 : (u == 1) ? 2 : (u == 2) ? 4 : 6), 32'(usb_clock_divider));
    chk("out_div", 32'(div_m), 32'(clock_output_divider));
    chk("out_illegal", 32'(cfg_m[31:28] < 4'h2), 32'(clock_output_div_illegal));
    chk("out_sel", cfg_m[26] ? 32'(cfg_m[26:24]) : 32'h0, 32'(clock_output_select));
    chk("predivider", 32'(cfg_m[17]), 32'(pll_ext_predivider));
    chk("pll_source", 32'(cfg_m[16]), 32'(pll_input_source));
    chk("pll_enable", 32'(en_m), 32'(pll_enable));
  endtask : chk_fields

  function automatic logic [31:0] exp_rd(input logic [7:0] adr);
    if (adr == ccf_pkg::ADDR_CFG) return cfg_m;
    if (adr == ccf_pkg::ADDR_CTRL) return {7'h0, en_m, 24'h0};
    return 32'h0;
  endfunction : exp_rd

  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int          i;
    logic [31:0] wm;
    @(posedge clk_sys);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_sel   <= sel;
    wb_dat_w <= dat;
    for (i = 0; i < 20 && wb_ack !== 1'b1; i++) @(posedge clk_sys);
    if (i >= 20) begin
      n_errors++;
      $display("ERROR wb_ack expected 1 seen 0");
      complete_run();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (we && adr == ccf_pkg::ADDR_CFG) begin
      wm    = {{8{sel[3]}}, {8{sel[2]}}, 16'h0} & ~(en_m ? ccf_pkg::CFG_LOCK_MASK : 32'h0);
      cfg_m = (cfg_m & ~wm) | (dat & wm);
      if (cfg_m[31:28] >= 4'h2) div_m = cfg_m[31:28];
    end else if (we && adr == ccf_pkg::ADDR_CTRL && sel[3]) begin
      if (dat[24]) en_m = 1'b1;
      else if (!(en_m && pll_drives_system_clock)) en_m = 1'b0;
    end
  endtask : wb

  task automatic rd_chk(input logic [7:0] adr);
    wb(1'b0, adr, 4'hf, 32'h0);
    chk("read", exp_rd(adr), rd);
  endtask : rd_chk

  task automatic settle_chk();
    repeat (2) @(posedge clk_sys);
    #1;
    chk_fields();
    rd_chk(ccf_pkg::ADDR_CFG);
  endtask : settle_chk

  task automatic reset_chk();
    cfg_m = ccf_pkg::CFG_RESET;
    en_m  = 1'b0;
    div_m = 4'h2;
    @(posedge clk_sys);
    #1;
    chk_fields();
    rd_chk(ccf_pkg::ADDR_CFG);
    rd_chk(ccf_pkg::ADDR_CTRL);
  endtask : reset_chk

  task automatic ctrl_wr(input logic [3:0] sel, input logic [31:0] dat);
    wb(1'b1, ccf_pkg::ADDR_CTRL, sel, dat);
    settle_chk();
  endtask : ctrl_wr

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    seed = 32'h01f14d5b;
    n_errors = 0;
    check_count = 0;
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    low_power_entry = 1'b0;
    pll_drives_system_clock = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    reset_chk();
    for (k = 0; k < 40; k++) begin
      d = $random(seed);
      d[31:28] = (k < 32) ? k[3:0] : d[31:28];
      d[27] = (k < 32) ? k[4] : d[27];
      d[26:24] = (k < 32) ? k[2:0] : d[26:24];
      d[23:22] = (k < 32) ? k[1:0] : d[23:22];
      d[21:18] = (k < 32) ? k[3:0] : d[21:18];
      d[15:14] = 2'h0;
      // No oscillator or USB clock runs in the bench, so every setting keeps the frequency limits.
      wb(1'b1, ccf_pkg::ADDR_CFG, (k < 32) ? 4'hf : 4'($random(seed)), d);
      settle_chk();
      if (k == 20) ctrl_wr(4'hf, 32'h0100_0000);
      if (k == 28) ctrl_wr(4'hf, 32'h0);
    end
    ctrl_wr(4'h7, 32'h0100_0000);
    ctrl_wr(4'h8, 32'h0100_0000);
    pll_drives_system_clock <= 1'b1;
    ctrl_wr(4'hf, 32'h0);
    wb(1'b1, ccf_pkg::ADDR_CFG, 4'hf, ~cfg_m & 32'hffff_3fff);
    settle_chk();
    pll_drives_system_clock <= 1'b0;
    ctrl_wr(4'hf, 32'h0);
    ctrl_wr(4'hf, 32'h0100_0000);
    @(posedge clk_sys);
    low_power_entry <= 1'b1;
    @(posedge clk_sys);
    #1;
    en_m = 1'b0;
    chk("pll_enable", 32'(en_m), 32'(pll_enable));
    @(posedge clk_sys);
    low_power_entry <= 1'b0;
    wb(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    rd_chk(8'h08);
    rd_chk(8'hfc);
    settle_chk();
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    reset_chk();
    complete_run();
  end
endmodule : tb_ccf_clock_config
`default_nettype wire
